// ---- hw/spimsp_pkg.sv ----
// Shared constants of the serial port and its input synchroniser.
`timescale 1ns/1ns
package spimsp_pkg;
  localparam int CHAR_BITS = 8;
  localparam int NUM_CS = 4;
  localparam int DIV_W = 8;
  localparam int CS_SEL_W = 2;
  localparam int EDGE_W = 5;
  localparam int BIT_CNT_W = 4;
  localparam logic [EDGE_W-1:0] LAST_EDGE = 5'h0f;
  localparam logic [BIT_CNT_W-1:0] CHAR_DONE = 4'h8;
  localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
  localparam logic [NUM_CS-1:0] CS_IDLE = 4'hf;
  localparam logic [CHAR_BITS-1:0] CHAR_RESET = 8'h00;
  localparam int SYNC_W = 4;
  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_RUN, ST_DONE} spimsp_state_t;
endpackage : spimsp_pkg

// Two-flop synchroniser for each pin that enters the core clock domain.
module spimsp_sync
  import spimsp_pkg::*;
(
  input wire logic core_clk, // Core clock.
  input wire logic reset, // Synchronous reset.
  input wire logic [SYNC_W-1:0] async_in, // Pin levels.
  output logic [SYNC_W-1:0] sync_out // Synchronised levels.
);
  logic [SYNC_W-1:0] first_stage;

  for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
    always_ff @(posedge core_clk) begin
      if (reset) begin
        first_stage[i] <= 1'b1;
        sync_out[i] <= 1'b1;
      end else begin
        first_stage[i] <= async_in[i];
        sync_out[i] <= first_stage[i];
      end
    end
  end
endmodule : spimsp_sync

// ---- hw/spimsp_port.sv ----
// Master and slave serial port with its documented silicon behaviour.
`timescale 1ns/1ns
//
// Contract
// - No transmit underrun flag in slave mode; a lost char goes unreported.
// - Mixed divisors, one equal to 1, polarity 1, phase 0: extra pulse.
// - Slave receive ready may assert falsely at the command that enables the port.
// - A disable command does not stop the port in slave mode.
module spimsp_port
  import spimsp_pkg::*;
(
  input wire logic core_clk, // Core clock, 250 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic sw_reset, // Software reset pulse of the port.
  input wire logic enable_cmd, // Enable command pulse.
  input wire logic disable_cmd, // Disable command pulse.
  input wire logic slave_mode, // 1 selects slave, 0 master.
  input wire logic clock_polarity, // Idle level of the serial clock.
  input wire logic clock_phase, // 1 samples on the trailing edge.
  input wire logic alt_clock_divide_select, // Alternate divide option.
  input wire logic [NUM_CS-1:0][DIV_W-1:0] serial_clock_divisor, // Per CS.
  input wire logic [NUM_CS-1:0] cs_in_use, // Chip selects in use.
  input wire logic [CS_SEL_W-1:0] tx_cs_sel, // CS for the written char.
  input wire logic [CHAR_BITS-1:0] tx_data, // Transmit character.
  input wire logic tx_write, // Transmit holding write pulse.
  input wire logic rx_read, // Receive holding read pulse.
  output logic tx_empty, // Transmit holding register empty.
  output logic [CHAR_BITS-1:0] receive_holding_register, // Last char.
  output logic receive_ready_flag, // New character present.
  output logic port_enabled, // Port enabled state.
  output logic busy, // Master transfer in progress.
  input wire logic sck_in, // Serial clock pin input.
  output logic sck_out, // Serial clock pin output.
  output logic sck_oe, // Serial clock output enable.
  input wire logic mosi_in, // Master-out pin input.
  output logic mosi_out, // Master-out pin output.
  output logic mosi_oe, // Master-out output enable.
  input wire logic miso_in, // Master-in pin input.
  output logic miso_out, // Master-in pin output.
  output logic miso_oe, // Master-in output enable.
  input wire logic slave_select_n_in, // Slave select pin, active low.
  output logic [NUM_CS-1:0] cs_n_out // Chip select outputs, active low.
);
  typedef struct packed {
    spimsp_state_t st;
    logic enabled;
    logic [DIV_W-1:0] div_cnt;
    logic [EDGE_W-1:0] edge_cnt;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [CS_SEL_W-1:0] cur_cs;
    logic [CHAR_BITS-1:0] tx_sh;
    logic [CHAR_BITS-1:0] rx_sh;
    logic [CHAR_BITS-1:0] tx_hold;
    logic hold_full;
    logic [CHAR_BITS-1:0] rx_data;
    logic rx_ready;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic [NUM_CS-1:0] cs_n;
    logic sck_prev;
    logic sel_prev_n;
  } spimsp_regs_t;

  localparam spimsp_regs_t REGS_RESET = '{
    st: ST_IDLE, enabled: 1'b0, div_cnt: DIV_ZERO, edge_cnt: '0,
    bit_cnt: '0, cur_cs: '0, tx_sh: CHAR_RESET, rx_sh: CHAR_RESET,
    tx_hold: CHAR_RESET, hold_full: 1'b0, rx_data: CHAR_RESET,
    rx_ready: 1'b0, sck: 1'b0, mosi: 1'b0, miso: 1'b0, miso_oe: 1'b0,
    cs_n: CS_IDLE, sck_prev: 1'b1, sel_prev_n: 1'b1};

  spimsp_regs_t r;
  spimsp_regs_t next_r;
  logic [SYNC_W-1:0] pins_sync;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic sel_n_s;
  logic any_div_one;
  logic any_div_other;
  logic extra_pulse;
  logic [DIV_W-1:0] half_period;
  logic [DIV_W-1:0] sel_div;

  spimsp_sync u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({sck_in, mosi_in, miso_in, slave_select_n_in}),
    .sync_out(pins_sync)
  );

  assign sck_s = pins_sync[3];
  assign mosi_s = pins_sync[2];
  assign miso_s = pins_sync[1];
  assign sel_n_s = pins_sync[0];

  always_comb begin
    any_div_one = 1'b0;
    any_div_other = 1'b0;
    for (int i = 0; i < NUM_CS; i++) begin
      if (cs_in_use[i] && serial_clock_divisor[i] == DIV_ONE) begin
        any_div_one = 1'b1;
      end else if (cs_in_use[i]) begin
        any_div_other = 1'b1;
      end
    end
  end

  // The silicon fault: mixed divisors in polarity 1, phase 0 add a pulse.
  assign extra_pulse = any_div_one && any_div_other && clock_polarity &&
                       !clock_phase;

  // The alternate divide option is not honoured; the plain divisor is used.
  assign sel_div = serial_clock_divisor[r.cur_cs];
  assign half_period = (sel_div == DIV_ZERO) ? DIV_ONE : sel_div;

  always_comb begin
    logic lead;
    logic trail;
    logic sck_edge;
    lead = 1'b0;
    trail = 1'b0;
    sck_edge = 1'b0;
    next_r = r;
    next_r.sck_prev = sck_s;
    next_r.sel_prev_n = sel_n_s;

    if (rx_read) begin
      next_r.rx_ready = 1'b0;
    end

    if (enable_cmd) begin
      next_r.enabled = 1'b1;
      if (slave_mode && !r.enabled) begin
        next_r.rx_ready = 1'b1;
      end
    end else if (disable_cmd && !slave_mode) begin
      next_r.enabled = 1'b0;
    end

    if (tx_write) begin
      next_r.tx_hold = tx_data;
      next_r.hold_full = 1'b1;
      next_r.cur_cs = (r.st == ST_IDLE) ? tx_cs_sel : r.cur_cs;
    end

    if (!slave_mode) begin
      next_r.miso_oe = 1'b0;
      case (r.st)
        ST_IDLE: begin
          next_r.sck = clock_polarity;
          if (r.enabled && r.hold_full && !tx_write) begin
            next_r.tx_sh = r.tx_hold;
            next_r.hold_full = 1'b0;
            next_r.mosi = r.tx_hold[CHAR_BITS-1];
            next_r.cs_n = CS_IDLE;
            next_r.cs_n[r.cur_cs] = 1'b0;
            next_r.edge_cnt = '0;
            next_r.div_cnt = half_period - DIV_ONE;
            next_r.st = extra_pulse ? ST_PULSE : ST_RUN;
          end
        end
        ST_PULSE: begin
          if (r.div_cnt == DIV_ZERO) begin
            next_r.div_cnt = half_period - DIV_ONE;
            next_r.sck = !r.sck;
            if (r.sck != clock_polarity) begin
              next_r.st = ST_RUN;
            end
          end else begin
            next_r.div_cnt = r.div_cnt - DIV_ONE;
          end
        end
        ST_RUN: begin
          if (r.div_cnt == DIV_ZERO) begin
            next_r.div_cnt = half_period - DIV_ONE;
            next_r.sck = !r.sck;
            next_r.edge_cnt = r.edge_cnt + 5'h01;
            lead = !r.edge_cnt[0];
            trail = r.edge_cnt[0];
            if (r.edge_cnt == LAST_EDGE) begin
              next_r.st = ST_DONE;
            end
          end else begin
            next_r.div_cnt = r.div_cnt - DIV_ONE;
          end
          if ((clock_phase ? trail : lead)) begin
            next_r.rx_sh = {r.rx_sh[CHAR_BITS-2:0], miso_s};
          end
          if (clock_phase ? lead : trail) begin
            if (clock_phase) begin
              next_r.mosi = r.tx_sh[CHAR_BITS-1];
            end else begin
              next_r.tx_sh = {r.tx_sh[CHAR_BITS-2:0], 1'b0};
              next_r.mosi = r.tx_sh[CHAR_BITS-2];
            end
          end
          if (clock_phase && trail) begin
            next_r.tx_sh = {r.tx_sh[CHAR_BITS-2:0], 1'b0};
          end
        end
        default: begin
          if (r.div_cnt == DIV_ZERO) begin
            next_r.cs_n = CS_IDLE;
            next_r.rx_data = r.rx_sh;
            next_r.rx_ready = 1'b1;
            next_r.st = ST_IDLE;
          end else begin
            next_r.div_cnt = r.div_cnt - DIV_ONE;
          end
        end
      endcase
    end else begin
      next_r.st = ST_IDLE;
      next_r.cs_n = CS_IDLE;
      next_r.sck = clock_polarity;
      next_r.miso_oe = r.enabled && !sel_n_s;
      sck_edge = r.enabled && !sel_n_s && (sck_s != r.sck_prev);
      lead = sck_edge && (r.sck_prev == clock_polarity);
      trail = sck_edge && (r.sck_prev != clock_polarity);
      if (r.enabled && r.sel_prev_n && !sel_n_s) begin
        next_r.bit_cnt = '0;
        // An empty holding register resends the old shift value silently.
        if (r.hold_full) begin
          next_r.tx_sh = r.tx_hold;
          next_r.hold_full = 1'b0;
          next_r.miso = r.tx_hold[CHAR_BITS-1];
        end else begin
          next_r.miso = r.tx_sh[CHAR_BITS-1];
        end
      end else if (clock_phase ? trail : lead) begin
        next_r.rx_sh = {r.rx_sh[CHAR_BITS-2:0], mosi_s};
        next_r.bit_cnt = r.bit_cnt + 4'h1;
        if (r.bit_cnt + 4'h1 == CHAR_DONE) begin
          next_r.rx_data = {r.rx_sh[CHAR_BITS-2:0], mosi_s};
          next_r.rx_ready = 1'b1;
          next_r.bit_cnt = '0;
          if (r.hold_full) begin
            next_r.tx_sh = r.tx_hold;
            next_r.hold_full = 1'b0;
          end
        end
      end else if ((clock_phase ? lead : trail) && r.bit_cnt != '0) begin
        next_r.tx_sh = {r.tx_sh[CHAR_BITS-2:0], 1'b0};
        next_r.miso = r.tx_sh[CHAR_BITS-2];
      end else if (clock_phase && lead) begin
        next_r.miso = r.tx_sh[CHAR_BITS-1];
      end
    end

    if (sw_reset) begin
      next_r = REGS_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      r <= REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_empty <= 1'b1;
      receive_holding_register <= CHAR_RESET;
      receive_ready_flag <= 1'b0;
      port_enabled <= 1'b0;
      busy <= 1'b0;
      sck_out <= 1'b0;
      sck_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      cs_n_out <= CS_IDLE;
    end else begin
      tx_empty <= !next_r.hold_full;
      receive_holding_register <= next_r.rx_data;
      receive_ready_flag <= next_r.rx_ready;
      port_enabled <= next_r.enabled;
      busy <= next_r.st != ST_IDLE;
      sck_out <= next_r.sck;
      sck_oe <= next_r.enabled && !slave_mode;
      mosi_out <= next_r.mosi;
      mosi_oe <= next_r.enabled && !slave_mode;
      miso_out <= next_r.miso;
      miso_oe <= next_r.miso_oe;
      cs_n_out <= next_r.cs_n;
    end
  end
endmodule : spimsp_port

// ---- tb/spi_master_slave_port_errata_tb.sv ----
// Self-checking bench of the serial port against a behavioural peer.
`timescale 1ns/1ns
module spi_master_slave_port_errata_tb
  import spimsp_pkg::*;
;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin \
    num_errors++; $display("[FAIL] %0t got %h want %h", $time, a, b); \
  end end
  logic core_clk = 1'b0, reset = 1'b1, sw_reset = 1'b0, enable_cmd = 1'b0;
  logic disable_cmd = 1'b0, slave_mode = 1'b0, clock_polarity = 1'b0;
  logic clock_phase = 1'b0, tx_write = 1'b0, rx_read = 1'b0, sck_q = 1'b0;
  logic alt_clock_divide_select = 1'b0;
  logic [NUM_CS-1:0][DIV_W-1:0] serial_clock_divisor = {4{8'h04}};
  logic [NUM_CS-1:0] cs_in_use = 4'h1;
  logic [CS_SEL_W-1:0] tx_cs_sel = 2'h0;
  logic [CHAR_BITS-1:0] tx_data = 8'h00, reply = 8'h3c;
  logic tx_empty, receive_ready_flag, port_enabled, busy, sck_out, sck_oe;
  logic mosi_out, mosi_oe, miso_out, miso_oe, p_miso, p_mosi, p_sck, p_ss_n;
  logic [CHAR_BITS-1:0] receive_holding_register, p_got;
  logic [NUM_CS-1:0] cs_n_out;
  wire logic sck_in = sck_oe ? sck_out : p_sck;
  wire logic mosi_in = mosi_oe ? mosi_out : p_mosi;
  wire logic miso_in = miso_oe ? miso_out : p_miso;
  wire logic slave_select_n_in = p_ss_n;
  int num_errors = 0, checks = 0, falls = 0;
  spimsp_port u_dut (.*);
  spimsp_peer u_peer (.sck(sck_in), .cs_n(&cs_n_out), .reply(reply),
    .mosi_i(mosi_in), .miso_i(miso_in),
    .miso_o(p_miso), .mosi_o(p_mosi), .sck_o(p_sck), .ss_n_o(p_ss_n),
    .got(p_got));
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (sck_q === 1'b1 && sck_out === 1'b0) falls++;
    sck_q <= sck_out;
  end
  task automatic close_out;
    $display("Errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // Pulse index: 0 read, 1 enable, 2 disable, 3 soft reset.
  task automatic pulse(input int k);
    @(posedge core_clk);
    {sw_reset, disable_cmd, enable_cmd, rx_read} <= 4'h1 << k;
    @(posedge core_clk);
    {sw_reset, disable_cmd, enable_cmd, rx_read} <= 4'h0;
    @(posedge core_clk);
  endtask : pulse
  task automatic xfer(input logic [1:0] sel);
    int n;
    n = 0;
    @(posedge core_clk);
    tx_cs_sel <= sel;
    tx_data <= 8'ha5;
    tx_write <= 1'b1;
    @(posedge core_clk);
    tx_write <= 1'b0;
    repeat (3) @(posedge core_clk);
    if (!slave_mode) `CHK(cs_n_out[sel], 1'b0)
    while (busy !== 1'b0 && n < 900) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 900) begin
      $display("[FAIL] %0t transfer timed out", $time);
      num_errors++;
      close_out();
    end
    @(posedge core_clk);
  endtask : xfer
  task automatic t_master;
    pulse(1);
    xfer(2'h0);
    `CHK(receive_holding_register, reply)
    `CHK(receive_ready_flag, 1'b1)
    `CHK(p_got, 8'ha5)
    pulse(0);
    `CHK(receive_ready_flag, 1'b0)
  endtask : t_master
  task automatic t_pulses;
    int base;
    @(posedge core_clk);
    clock_polarity <= 1'b1;
    cs_in_use <= 4'h3;
    serial_clock_divisor[0] <= 8'h01;
    repeat (4) @(posedge core_clk);
    base = falls;
    xfer(2'h1);
    `CHK(falls - base, 9)
    serial_clock_divisor[1] <= 8'h01;
    repeat (4) @(posedge core_clk);
    base = falls;
    xfer(2'h1);
    `CHK(falls - base, 8)
  endtask : t_pulses
  task automatic t_slave;
    @(posedge core_clk);
    slave_mode <= 1'b1;
    clock_polarity <= 1'b0;
    serial_clock_divisor <= {4{8'h04}};
    pulse(3);
    pulse(1);
    `CHK(receive_ready_flag, 1'b1)
    clock_polarity <= 1'b1;
    @(posedge core_clk);
    clock_polarity <= 1'b0;
    pulse(0);
    `CHK(receive_ready_flag, 1'b0)
    xfer(2'h0);
    `CHK(tx_empty, 1'b0)
    u_peer.send(8'hc3);
    repeat (8) @(posedge core_clk);
    `CHK(receive_holding_register, 8'hc3)
    `CHK(receive_ready_flag, 1'b1)
    `CHK(p_got, 8'ha5)
    `CHK(tx_empty, 1'b1)
    pulse(2);
    `CHK(port_enabled, 1'b1)
    `CHK({sck_oe, mosi_oe}, 2'h0)
    pulse(0);
    pulse(3);
    `CHK(port_enabled, 1'b0)
    `CHK(receive_ready_flag, 1'b0)
  endtask : t_slave
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_master();
    t_pulses();
    t_slave();
    close_out();
  end
endmodule : spi_master_slave_port_errata_tb

// ---- tb/spimsp_checker.sv ----
// Concurrent checks on the serial port's flags and serial clock.
`timescale 1ns/1ns
module spimsp_checker
  import spimsp_pkg::*;
(
  input wire logic core_clk, // Clock.
  input wire logic reset, // Reset.
  input wire logic sw_reset, // Soft reset.
  input wire logic enable_cmd, // Enable.
  input wire logic disable_cmd, // Disable.
  input wire logic slave_mode, // Mode.
  input wire logic clock_polarity, // Polarity.
  input wire logic clock_phase, // Phase.
  input wire logic [NUM_CS-1:0][DIV_W-1:0] serial_clock_divisor, // Divs.
  input wire logic [NUM_CS-1:0] cs_in_use, // In use.
  input wire logic rx_read, // Read.
  input wire logic receive_ready_flag, // Ready.
  input wire logic port_enabled, // Enabled.
  input wire logic busy, // Busy.
  input wire logic sck_out // Clock pin.
);
  logic mix, sck_q, one, other;
  logic [3:0] falls;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (reset);
  always_comb begin
    one = 1'b0;
    other = 1'b0;
    for (int i = 0; i < NUM_CS; i++) begin
      one |= cs_in_use[i] && serial_clock_divisor[i] == DIV_ONE;
      other |= cs_in_use[i] && serial_clock_divisor[i] != DIV_ONE;
    end
  end
  // Falling clock edges are counted over each master transfer.
  always_ff @(posedge core_clk) begin
    sck_q <= sck_out;
    if (reset || !busy) falls <= 4'h0;
    else if (sck_q && !sck_out) falls <= falls + 4'h1;
    if (!busy) mix <= clock_polarity && !clock_phase && one && other;
  end
  extra_pulse_a: assert property ($fell(busy) |->
    falls == (mix ? 4'h9 : 4'h8)) else $error("sck pulse count wrong");
  false_ready_a: assert property (enable_cmd && slave_mode
    && !port_enabled && !sw_reset |=> receive_ready_flag)
    else $error("no ready on slave enable");
  no_disable_a: assert property (disable_cmd && slave_mode
    && port_enabled && !sw_reset |=> port_enabled)
    else $error("slave port stopped");
  read_clear_a: assert property (rx_read && !busy && !slave_mode
    && !enable_cmd |=> !receive_ready_flag) else $error("ready kept");
  soft_stop_a: assert property (sw_reset |=> !port_enabled
    && !busy && !receive_ready_flag) else $error("soft reset left state");
endmodule : spimsp_checker

bind spimsp_port spimsp_checker u_chk (.*);

// ---- tb/spimsp_peer.sv ----
// Behavioural peer: slave to the port as master, master to it as slave.
`timescale 1ns/1ns
module spimsp_peer (
  input wire logic sck, // Serial clock.
  input wire logic cs_n, // Port chip selects, low when any is active.
  input wire logic [7:0] reply, // Slave reply.
  input wire logic mosi_i, // Master-out line as seen on the bus.
  input wire logic miso_i, // Master-in line as seen on the bus.
  output logic miso_o, // Slave data out.
  output logic mosi_o, // Master data out.
  output logic sck_o, // Master clock.
  output logic ss_n_o, // Master select, active low.
  output logic [7:0] got // Last character captured from the port.
);
  logic [7:0] sh = 8'h00;
  initial begin
    {miso_o, mosi_o, sck_o, ss_n_o} = 4'h1;
  end
  always @(negedge cs_n) {miso_o, sh} = {reply, 1'b0};
  always @(negedge sck) if (!cs_n) {miso_o, sh} = {sh, 1'b0};
  // A released line shows the inverse of its last bit.
  always @(posedge cs_n) miso_o = ~miso_o;
  // Rising clock edges capture whatever the port drives toward the peer.
  always @(posedge sck) begin
    if (!cs_n) got = {got[6:0], mosi_i};
    else if (!ss_n_o) got = {got[6:0], miso_i};
  end
  task automatic send(input logic [7:0] c);
    #1 ss_n_o = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_o = c[i];
      #32 sck_o = 1'b1;
      #32 sck_o = 1'b0;
    end
    #32 ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask : send
endmodule : spimsp_peer
